// *** core/smsl_pkg.sv ***
// package: constants and types of the smbus slave port
package smsl_pkg;

   // ==========================================================
   // slave addressing
   localparam logic [3:0] ADDR_UPPER       = 4'h_000a;
   localparam logic [6:0] ADDR_BROADCAST   = 7'h_0057;
   localparam logic [2:0] LOW_EXT0_GND     = 3'h_0;
   localparam logic [2:0] LOW_EXT0_VDD     = 3'h_1;
   localparam logic [2:0] LOW_EXT0_OPEN    = 3'h_4;
   localparam logic [2:0] LOW_EXT1_GND     = 3'h_2;
   localparam logic [2:0] LOW_EXT1_VDD     = 3'h_3;
   localparam logic [2:0] LOW_EXT1_OPEN    = 3'h_5;
   localparam logic       EXT_BIT_RESET    = 1'h_0;

   // ==========================================================
   // command bytes and memory map
   localparam logic [7:0] RAM_TOP          = 8'h_007f;
   localparam logic [7:0] NV_HI_FRU        = 8'h_0080;
   localparam logic [7:0] NV_HI_DEFAULTS   = 8'h_0081;
   localparam logic [7:0] CMD_PAGE_ERASE   = 8'h_00a2;
   localparam int         NV_BIT           = 15;
   localparam int         PAGE_OFS_BITS    = 5;

   // ==========================================================
   // byte framing
   localparam logic [3:0] BITS_PER_BYTE    = 4'h_8;
   localparam logic [2:0] IDX_ADDR         = 3'h_0;
   localparam logic [2:0] IDX_CMD          = 3'h_1;
   localparam logic [2:0] IDX_ARG1         = 3'h_2;
   localparam logic [2:0] IDX_ARG2         = 3'h_3;
   localparam logic [2:0] IDX_DATA         = 3'h_4;

   // ==========================================================
   // timing
   localparam int CLK_HZ          = 10_000_000;
   localparam int ERASE_TIME_MS   = 20;
   localparam int ERASE_CYCLES    = (CLK_HZ / 1000) * ERASE_TIME_MS;
   localparam int BUSY_W          = 18;

   // ==========================================================
   // request path towards the memory
   localparam int FIFO_DEPTH      = 8;
   localparam int REQ_W           = 25;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_RX   = 6'b00_0010,
      ST_ACK  = 6'b00_0100,
      ST_TX   = 6'b00_1000,
      ST_MACK = 6'b01_0000,
      ST_WAIT = 6'b10_0000
   } smsl_state_t;

endpackage

// *** core/smsl_slave.sv ***
// smbus slave port: byte engine, address decode, erase timer and fifo
// Operation
// - slave only, never drives start or clock
// - also answers broadcast address 1010111, write direction only
// - address 1010 plus three strap-derived bits
// - strap and extension bit select low bits
// - extension bit latched once after boot download
// - start then eight bits, msb first
// - direction bit zero writes, one reads
// - matched address acknowledged through ninth clock
// - mismatch: wait state until start or stop, line released
// - nine clocks per byte; stop ends transfer
// - first written byte is command byte
// - read ends with master nack then stop
// - repeated start begins new address phase
// - ram 00h-7Fh, nonvolatile from 8000h
// - nonvolatile rewrite needs page erase first
// - command A2h plus page starts erase
// - nonvolatile memory sixteen pages, 32 bytes
// - defaults page 8100h-811Fh loaded at power-up
// - erase page: high byte, top three bits
// - erase busy 20 ms, nonvolatile access nacked

// ==========================================================
// fifo with flip-flop storage
module smsl_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // fill side
   input  wire logic         s_valid,
   output logic              s_ready,
   input  wire logic [W-1:0] s_data,
   // drain side
   output logic              m_valid,
   input  wire logic         m_ready,
   output logic [W-1:0]      m_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } smsl_fifo_t;

   smsl_fifo_t q;
   smsl_fifo_t d;
   logic       do_wr;
   logic       do_rd;

   always_comb
   begin
      d       = q;
      s_ready = (q.cnt != (AW+1)'(D));
      m_valid = (q.cnt != '0);
      m_data  = q.mem[q.rp];
      do_wr   = s_valid && s_ready;
      do_rd   = m_valid && m_ready;
      if (do_wr)
      begin
         d.mem[q.wp] = s_data;
         d.wp        = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
      end
      if (do_rd)
      begin
         d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
         d.cnt = q.cnt + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end
endmodule // smsl_fifo

// ==========================================================
// top: slave port
module smsl_slave #(
   parameter int ERASE_CYCLES = smsl_pkg::ERASE_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // bus pins (data line is open drain)
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   // address strap and boot configuration
   input  wire logic        addr_strap_pin_vdd,
   input  wire logic        addr_strap_pin_gnd,
   input  wire logic        addr_extend_bit,
   input  wire logic        boot_load_done,
   // request stream to memory
   output logic             mem_valid,
   input  wire logic        mem_ready,
   output logic             mem_erase,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_data,
   // read path
   output logic [15:0]      rd_addr,
   input  wire logic [7:0]  rd_data,
   // status
   output logic             erase_busy
);

   typedef struct packed {
      logic                       scl_s1;
      logic                       scl_s2;
      logic                       scl_s3;
      logic                       sda_s1;
      logic                       sda_s2;
      logic                       sda_s3;
      logic                       vdd_s1;
      logic                       vdd_s2;
      logic                       gnd_s1;
      logic                       gnd_s2;
      smsl_pkg::smsl_state_t      st;
      logic [3:0]                 bit_cnt;
      logic [2:0]                 byte_idx;
      logic [7:0]                 sh;
      logic                       rw;
      logic [7:0]                 cmd;
      logic [15:0]                ptr;
      logic [7:0]                 ehi;
      logic                       sda_oe_n;
      logic                       ext;
      logic                       latched;
      logic [2:0]                 low3;
      logic [smsl_pkg::BUSY_W-1:0] busy_cnt;
      logic                       busy;
      logic                       push;
      logic [smsl_pkg::REQ_W-1:0] push_d;
      logic                       out_v;
      logic [smsl_pkg::REQ_W-1:0] out_d;
   } smsl_state_reg_t;

   smsl_state_reg_t q;
   smsl_state_reg_t d;

   logic                       f_s_ready;
   logic                       f_m_valid;
   logic                       f_m_ready;
   logic [smsl_pkg::REQ_W-1:0] f_m_data;

   smsl_fifo #(
      .W (smsl_pkg::REQ_W),
      .D (smsl_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk     (clk),
      .srst    (srst),
      .s_valid (q.push),
      .s_ready (f_s_ready),
      .s_data  (q.push_d),
      .m_valid (f_m_valid),
      .m_ready (f_m_ready),
      .m_data  (f_m_data)
   );

   // output stage: memory-side outputs from flops
   assign f_m_ready = !q.out_v || mem_ready;

   always_comb
   begin
      logic       scl_rise;
      logic       scl_fall;
      logic       start_c;
      logic       stop_c;
      logic [2:0] strap_low;
      logic [7:0] b;
      logic       ack;
      logic       nv_block;
      logic       room;
      scl_rise  = q.scl_s2 && !q.scl_s3;
      scl_fall  = !q.scl_s2 && q.scl_s3;
      start_c   = q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
      stop_c    = q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2;
      strap_low = '0;
      b         = '0;
      ack       = 1'b0;
      nv_block  = 1'b0;
      room      = 1'b0;

      d = q;
      d.push = 1'b0;

      // ======================================================
      // pin synchronisers
      d.scl_s1 = scl_in;
      d.scl_s2 = q.scl_s1;
      d.scl_s3 = q.scl_s2;
      d.sda_s1 = sda_in;
      d.sda_s2 = q.sda_s1;
      d.sda_s3 = q.sda_s2;
      d.vdd_s1 = addr_strap_pin_vdd;
      d.vdd_s2 = q.vdd_s1;
      d.gnd_s1 = addr_strap_pin_gnd;
      d.gnd_s2 = q.gnd_s1;

      // ======================================================
      // slave address low bits
      if (!q.latched && boot_load_done)
      begin
         d.ext     = addr_extend_bit;
         d.latched = 1'b1;
      end
      // open strap reads as neither rail
      if (q.gnd_s2)
      begin
         strap_low = q.ext ? smsl_pkg::LOW_EXT1_GND
                           : smsl_pkg::LOW_EXT0_GND;
      end
      else if (q.vdd_s2)
      begin
         strap_low = q.ext ? smsl_pkg::LOW_EXT1_VDD
                           : smsl_pkg::LOW_EXT0_VDD;
      end
      else
      begin
         strap_low = q.ext ? smsl_pkg::LOW_EXT1_OPEN
                           : smsl_pkg::LOW_EXT0_OPEN;
      end
      d.low3 = strap_low;

      // ======================================================
      // erase timer
      if (q.busy_cnt != '0)
      begin
         d.busy_cnt = q.busy_cnt - 1'b1;
      end
      d.busy = (d.busy_cnt != '0);
      room   = f_s_ready;

      // ======================================================
      // byte engine; the clock line is only ever read
      if (start_c)
      begin
         d.st       = smsl_pkg::ST_RX;
         d.bit_cnt  = '0;
         d.byte_idx = smsl_pkg::IDX_ADDR;
         d.sda_oe_n = 1'b1;
      end
      else if (stop_c)
      begin
         d.st       = smsl_pkg::ST_IDLE;
         d.sda_oe_n = 1'b1;
      end
      else
      begin
         unique case (q.st)
            smsl_pkg::ST_IDLE,
            smsl_pkg::ST_WAIT:
            begin
               d.sda_oe_n = 1'b1;
            end

            smsl_pkg::ST_RX:
            begin
               if (scl_rise && q.bit_cnt != smsl_pkg::BITS_PER_BYTE)
               begin
                  d.sh      = {q.sh[6:0], q.sda_s2};
                  d.bit_cnt = q.bit_cnt + 1'b1;
               end
               else if (scl_fall &&
                        q.bit_cnt == smsl_pkg::BITS_PER_BYTE)
               begin
                  b = q.sh;
                  nv_block = q.busy && q.ptr[smsl_pkg::NV_BIT];
                  if (q.byte_idx == smsl_pkg::IDX_ADDR)
                  begin
                     d.rw = b[0];
                     ack  = (b[7:1] == {smsl_pkg::ADDR_UPPER,
                                        q.low3}) ||
                            (b[7:1] == smsl_pkg::ADDR_BROADCAST &&
                             !b[0]);
                     if (b[0] && nv_block)
                     begin
                        ack = 1'b0;
                     end
                  end
                  else if (q.byte_idx == smsl_pkg::IDX_CMD)
                  begin
                     d.cmd = b;
                     ack   = 1'b1;
                     if (b <= smsl_pkg::RAM_TOP)
                     begin
                        d.ptr = {8'h_0000, b};
                     end
                     else if (b == smsl_pkg::NV_HI_FRU ||
                              b == smsl_pkg::NV_HI_DEFAULTS)
                     begin
                        d.ptr[15:8] = b;
                        ack = !q.busy;
                     end
                     else if (b == smsl_pkg::CMD_PAGE_ERASE)
                     begin
                        ack = !q.busy;
                     end
                  end
                  else if (q.cmd == smsl_pkg::CMD_PAGE_ERASE)
                  begin
                     ack = !q.busy;
                     if (q.byte_idx == smsl_pkg::IDX_ARG1)
                     begin
                        d.ehi = b;
                     end
                     else if (q.byte_idx == smsl_pkg::IDX_ARG2)
                     begin
                        ack = ack && room;
                        if (ack)
                        begin
                           d.push   = 1'b1;
                           d.push_d = {1'b1, q.ehi,
                                       b[7:smsl_pkg::PAGE_OFS_BITS],
                                       5'h_00, 8'h_00};
                           d.busy_cnt =
                              smsl_pkg::BUSY_W'(ERASE_CYCLES);
                        end
                     end
                  end
                  else if (q.cmd <= smsl_pkg::RAM_TOP)
                  begin
                     ack = room;
                     if (ack)
                     begin
                        d.push   = 1'b1;
                        d.push_d = {1'b0, q.ptr, b};
                        d.ptr    = q.ptr + 1'b1;
                     end
                  end
                  else if (q.cmd == smsl_pkg::NV_HI_FRU ||
                           q.cmd == smsl_pkg::NV_HI_DEFAULTS)
                  begin
                     ack = !q.busy;
                     if (q.byte_idx == smsl_pkg::IDX_ARG1)
                     begin
                        d.ptr[7:0] = b;
                     end
                     else
                     begin
                        ack = ack && room;
                        if (ack)
                        begin
                           d.push   = 1'b1;
                           d.push_d = {1'b0, q.ptr, b};
                           d.ptr    = q.ptr + 1'b1;
                        end
                     end
                  end
                  else
                  begin
                     ack = 1'b1;
                  end
                  if (q.byte_idx != smsl_pkg::IDX_DATA)
                  begin
                     d.byte_idx = q.byte_idx + 1'b1;
                  end
                  if (ack)
                  begin
                     d.sda_oe_n = 1'b0;
                     d.st       = smsl_pkg::ST_ACK;
                  end
                  else
                  begin
                     d.sda_oe_n = 1'b1;
                     d.st       = smsl_pkg::ST_WAIT;
                  end
               end
            end

            smsl_pkg::ST_ACK:
            begin
               // line held low across the whole ninth high phase
               if (scl_fall)
               begin
                  d.bit_cnt = '0;
                  if (q.rw)
                  begin
                     d.sh       = rd_data;
                     d.sda_oe_n = rd_data[7];
                     d.st       = smsl_pkg::ST_TX;
                  end
                  else
                  begin
                     d.sda_oe_n = 1'b1;
                     d.st       = smsl_pkg::ST_RX;
                  end
               end
            end

            smsl_pkg::ST_TX:
            begin
               if (scl_rise)
               begin
                  d.bit_cnt = q.bit_cnt + 1'b1;
               end
               else if (scl_fall)
               begin
                  if (q.bit_cnt == smsl_pkg::BITS_PER_BYTE)
                  begin
                     d.sda_oe_n = 1'b1;
                     d.st       = smsl_pkg::ST_MACK;
                  end
                  else
                  begin
                     d.sh       = {q.sh[6:0], 1'b0};
                     d.sda_oe_n = q.sh[6];
                  end
               end
            end

            smsl_pkg::ST_MACK:
            begin
               if (scl_rise)
               begin
                  if (q.sda_s2)
                  begin
                     d.st = smsl_pkg::ST_WAIT;
                  end
                  else
                  begin
                     d.ptr = q.ptr + 1'b1;
                  end
               end
               else if (scl_fall)
               begin
                  d.bit_cnt  = '0;
                  d.sh       = rd_data;
                  d.sda_oe_n = rd_data[7];
                  d.st       = smsl_pkg::ST_TX;
               end
            end
         endcase
      end

      // ======================================================
      // memory-side output stage
      if (f_m_ready)
      begin
         d.out_v = f_m_valid;
         d.out_d = f_m_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q          <= '0;
         q.scl_s1   <= 1'b1;
         q.scl_s2   <= 1'b1;
         q.scl_s3   <= 1'b1;
         q.sda_s1   <= 1'b1;
         q.sda_s2   <= 1'b1;
         q.sda_s3   <= 1'b1;
         q.st       <= smsl_pkg::ST_IDLE;
         q.sda_oe_n <= 1'b1;
         q.ext      <= smsl_pkg::EXT_BIT_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs from flops, sda_out tied low; data line only ever pulled low
   assign sda_out    = 1'b0;
   assign sda_oe_n   = q.sda_oe_n;
   assign mem_valid  = q.out_v;
   assign mem_erase  = q.out_d[24];
   assign mem_addr   = q.out_d[23:8];
   assign mem_data   = q.out_d[7:0];
   assign rd_addr    = q.ptr;
   assign erase_busy = q.busy;

endmodule // smsl_slave

// *** tb/smsl_slave_assertions.sv ***
// checker: bus pin and memory stream properties of the slave port
module smsl_slave_assertions #(
   parameter int ERASE_CYCLES = smsl_pkg::ERASE_CYCLES
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // bus pins
   input wire logic        scl_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_n,
   // memory stream and status
   input wire logic        mem_valid,
   input wire logic        mem_ready,
   input wire logic        mem_erase,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_data,
   input wire logic [15:0] rd_addr,
   input wire logic        erase_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   int busy_q;
   always_ff @(posedge clk) busy_q <= (srst || !erase_busy) ? 0 : busy_q + 1;
   property p_reset_vals;
      $fell(srst) |-> sda_oe_n && !mem_valid && !erase_busy
         && rd_addr == 16'h_0000;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("outputs not idle after reset");
   property p_open_drain;
      sda_out == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data line driven high");
   property p_sda_moves_low;
      $changed(sda_oe_n) |-> !scl_in;
   endproperty
   a_sda_moves_low: assert property (p_sda_moves_low)
      else $error("data line moved while clock high");
   property p_ack_holds;
      $rose(scl_in) && !sda_oe_n |=> !sda_oe_n [*2];
   endproperty
   a_ack_holds: assert property (p_ack_holds)
      else $error("pull released during clock high");
   property p_mem_hold;
      mem_valid && !mem_ready |=> mem_valid
         && $stable({mem_erase, mem_addr, mem_data});
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("memory request changed before taken");
   property p_erase_addr;
      mem_valid && mem_erase |-> mem_addr[15:9] == 7'h_40
         && mem_addr[4:0] == 5'h_00 && mem_data == 8'h_00;
   endproperty
   a_erase_addr: assert property (p_erase_addr)
      else $error("erase request not a page base");
   property p_erase_busy;
      mem_valid && mem_erase |-> erase_busy;
   endproperty
   a_erase_busy: assert property (p_erase_busy)
      else $error("erase issued without busy");
   property p_busy_max;
      erase_busy |-> busy_q <= ERASE_CYCLES;
   endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("erase busy too long");
   property p_busy_min;
      $fell(erase_busy) |-> busy_q >= ERASE_CYCLES - 1;
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("erase busy too short");
endmodule // smsl_slave_assertions

bind smsl_slave smsl_slave_assertions #(
   .ERASE_CYCLES(ERASE_CYCLES)
) u_chk (
   .clk, .srst, .scl_in, .sda_out, .sda_oe_n, .mem_valid, .mem_ready,
   .mem_erase, .mem_addr, .mem_data, .rd_addr, .erase_busy
);

// *** tb/smsl_bus_master.sv ***
// model of the bus master driving clock and open-drain data
module smsl_bus_master (
   // clock
   input  wire logic clk,
   // bus, data released while sda_o is 1
   output logic      scl,
   output logic      sda_o,
   input  wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic in_frame;
   initial
   begin
      scl      = 1'b1;
      sda_o    = 1'b1;
      in_frame = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   // 5 low, 3 high; data moves mid low phase
   task automatic bit_io(input logic b, output logic s);
      w(2);
      sda_o <= b;
      w(3);
      scl <= 1'b1;
      w(2);
      s = sda_i;
      w(1);
      scl <= 1'b0;
   endtask
   task automatic start();
      if (in_frame)
      begin
         w(2);
         sda_o <= 1'b1;
         w(3);
         scl <= 1'b1;
      end
      in_frame = 1'b1;
      w(2);
      sda_o <= 1'b0;
      w(4);
      scl <= 1'b0;
   endtask
   // clock then rests high
   task automatic stop();
      w(2);
      sda_o <= 1'b0;
      w(3);
      scl <= 1'b1;
      w(3);
      sda_o <= 1'b1;
      w(4);
      in_frame = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic rbyte(output logic [7:0] d, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!ack, s);
   endtask
endmodule // smsl_bus_master

// *** tb/smbus_slave_eeprom_access_tb.sv ***
// self-checking testbench of the smbus slave port
`define CHK(nm, ex, got) \
   begin \
      n_tests++; \
      if ((got) !== (ex)) \
      begin \
         failures++; \
         $display("[ERR] %s: expected %h, seen %h", nm, ex, got); \
      end \
   end

module smbus_slave_eeprom_access_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // short erase keeps the run brief
   localparam int ERASE = 2000;
   localparam int LIMIT = 60000;
   // ==========================================================
   // signals
   logic clk, sda_in, sda_out, sda_oe_n, scl, m_sda;
   logic srst = 1'b1, vdd = 1'b0, gnd = 1'b1, ext = 1'b0, boot = 1'b0;
   logic mem_ready = 1'b1;
   logic [7:0] rd_data = 8'h_0000;
   logic mem_valid, mem_erase, erase_busy;
   logic [15:0] mem_addr, rd_addr;
   logic [7:0] mem_data;
   logic [24:0] got_q [$];
   int failures = 0, n_tests = 0, cyc = 0;
   // pulled-up wired-and data line
   assign sda_in = m_sda & (sda_oe_n | sda_out);
   smsl_slave #(
      .ERASE_CYCLES(ERASE)
   ) u_dut (
      .clk, .srst, .scl_in(scl), .sda_in, .sda_out, .sda_oe_n,
      .addr_strap_pin_vdd(vdd), .addr_strap_pin_gnd(gnd),
      .addr_extend_bit(ext), .boot_load_done(boot),
      .mem_valid, .mem_ready, .mem_erase, .mem_addr, .mem_data,
      .rd_addr, .rd_data, .erase_busy
   );
   smsl_bus_master u_mst (.clk, .scl, .sda_o(m_sda), .sda_i(sda_in));
   // ==========================================================
   // clock, memory, monitor, limit
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) rd_data <= img(rd_addr);
   always @(posedge clk)
      if (mem_valid && mem_ready)
         got_q.push_back({mem_erase, mem_addr, mem_data});
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         failures++;
         $display("[ERR] cycles: expected below %0d, seen %0d", LIMIT, cyc);
         give_verdict();
      end
   end
   function automatic logic [7:0] img(input logic [15:0] a);
      return a[7:0] ^ 8'h_005a;
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ==========================================================
   // shared steps
   task automatic do_reset(input logic e, input int k);
      @(posedge clk);
      srst <= 1'b1;
      ext <= e;
      gnd <= (k == 0);
      vdd <= (k == 1);
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      boot <= 1'b1;
      @(posedge clk);
      // a later change must not move the address
      boot <= 1'b0;
      ext <= ~e;
      @(posedge clk);
      boot <= 1'b1;
      @(posedge clk);
      boot <= 1'b0;
   endtask
   task automatic send(input logic [7:0] bs [$], output logic [15:0] ak);
      logic a;
      ak = '0;
      u_mst.start();
      foreach (bs[i])
      begin
         u_mst.wbyte(bs[i], a);
         ak[i] = a;
      end
   endtask
   task automatic chk_req(input logic [24:0] ex);
      logic [24:0] g;
      g = 'x;
      for (int k = 0; k < 200 && got_q.size() == 0; k++)
         @(posedge clk);
      if (got_q.size() != 0)
         g = got_q.pop_front();
      `CHK("memory request", ex, g);
   endtask
   task automatic wait_idle();
      for (int k = 0; k < ERASE + 100 && erase_busy; k++)
         @(posedge clk);
      `CHK("busy over", 1'b0, erase_busy);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_addr();
      logic [2:0] lo [6] = '{3'h_0, 3'h_1, 3'h_4, 3'h_2, 3'h_3, 3'h_5};
      logic [15:0] ak;
      for (int i = 0; i < 6; i++)
      begin
         do_reset(i / 3, i % 3);
         send({{4'h_a, lo[i], 1'b0}}, ak);
         u_mst.stop();
         `CHK("own address", 16'h_0001, ak);
         send({{4'h_a, lo[i] ^ 3'h_1, 1'b0}, 8'h_00}, ak);
         `CHK("other address", 16'h_0000, ak);
         send({8'h_ae}, ak);
         u_mst.stop();
         `CHK("broadcast write", 16'h_0001, ak);
      end
      $display("test addressing done");
   endtask
   task automatic t_write();
      logic [15:0] ak;
      send({8'h_a0, 8'h_05, 8'h_3c, 8'h_3d}, ak);
      u_mst.stop();
      `CHK("ram write acks", 16'h_000f, ak);
      chk_req({1'b0, 16'h_0005, 8'h_3c});
      chk_req({1'b0, 16'h_0006, 8'h_3d});
      send({8'h_a0, 8'h_80, 8'h_40, 8'h_77}, ak);
      u_mst.stop();
      `CHK("nv write acks", 16'h_000f, ak);
      chk_req({1'b0, 16'h_8040, 8'h_77});
      $display("test write done");
   endtask
   task automatic t_read();
      logic [15:0] ak;
      logic [7:0] d0, d1;
      logic a;
      send({8'h_a0, 8'h_7f}, ak);
      u_mst.start();
      u_mst.wbyte(8'h_a1, a);
      u_mst.rbyte(d0, 1'b1);
      u_mst.rbyte(d1, 1'b0);
      u_mst.stop();
      `CHK("read address ack", 1'b1, a);
      `CHK("read data", {img(16'h_007f), img(16'h_0080)}, {d0, d1});
      `CHK("no request from read", 0, got_q.size());
      $display("test read done");
   endtask
   task automatic t_erase();
      logic [15:0] ak;
      send({8'h_a0, 8'h_a2, 8'h_81, 8'h_37}, ak);
      u_mst.stop();
      `CHK("erase acks", 16'h_000f, ak);
      chk_req({1'b1, 16'h_8120, 8'h_00});
      `CHK("busy", 1'b1, erase_busy);
      send({8'h_a0, 8'h_10, 8'h_55}, ak);
      u_mst.stop();
      `CHK("ram write while busy", 16'h_0007, ak);
      chk_req({1'b0, 16'h_0010, 8'h_55});
      send({8'h_a0, 8'h_80}, ak);
      u_mst.stop();
      `CHK("nv command while busy", 16'h_0001, ak);
      wait_idle();
      send({8'h_a0, 8'h_a2, 8'h_80, 8'h_ff}, ak);
      u_mst.stop();
      `CHK("second erase acks", 16'h_000f, ak);
      chk_req({1'b1, 16'h_80e0, 8'h_00});
      wait_idle();
      $display("test erase done");
   endtask
   task automatic t_fifo();
      logic [7:0] bs [$];
      logic [15:0] ak;
      bs = {8'h_a0, 8'h_20};
      for (int i = 0; i < 11; i++)
         bs.push_back(8'h_c0 + 8'(i));
      mem_ready <= 1'b0;
      send(bs, ak);
      u_mst.stop();
      // eight entries plus the output stage, then refusal
      `CHK("stalled acks", 16'h_07ff, ak);
      mem_ready <= 1'b1;
      for (int i = 0; i < 9; i++)
         chk_req({1'b0, 16'h_0020 + 16'(i), 8'h_c0 + 8'(i)});
      repeat (20) @(posedge clk);
      `CHK("drained", 0, got_q.size());
      $display("test buffering done");
   endtask
   initial
   begin
      t_addr();
      do_reset(1'b0, 0);
      t_write();
      t_read();
      t_erase();
      t_fifo();
      give_verdict();
   end
endmodule // smbus_slave_eeprom_access_tb
